// >>> core/vsq_pkg.sv
package vsq_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int START_WAIT_NS = 1360000;
   localparam int START_WAIT_CYC = START_WAIT_NS / CLK_PERIOD_NS;
   localparam int GOOD_DELAY_NS = 85000;
   localparam int GOOD_DELAY_CYC = GOOD_DELAY_NS / CLK_PERIOD_NS;
   localparam int TIMER_W = 18;
   localparam logic [TIMER_W-1:0] HICCUP_SW_CYCLES = 18'h01000;

   // ==========================================================
   // Channels, setpoint code and reference
   localparam int CHANNELS = 6;
   localparam int CODE_W = 8;
   localparam int REF_W = 9;
   localparam logic [REF_W-1:0] REF_CODE_BASE = 9'h102;
   localparam logic [CODE_W-1:0] OFF_CODE_A = 8'hfe;
   localparam logic [CODE_W-1:0] OFF_CODE_B = 8'hff;

   // ==========================================================
   // Register map and fields
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_INT_STAT = 12'h008;
   localparam logic [11:0] ADDR_INT_MASK = 12'h00c;
   localparam int CTRL_HOLD_OFF = 0;
   localparam int INT_W = 5;
   localparam int EV_OV = 0;
   localparam int EV_OC = 1;
   localparam int EV_UV = 2;
   localparam int EV_PG_RISE = 3;
   localparam int EV_CODE_OFF = 4;
   localparam logic [INT_W-1:0] INT_MASK_RESET = 5'h00;

   // ==========================================================
   // Sequencer states
   typedef enum logic [7:0] {
      ST_OFF = 8'h01,
      ST_WAIT = 8'h02,
      ST_RAMP = 8'h04,
      ST_GOOD_DLY = 8'h08,
      ST_RUN = 8'h10,
      ST_OC_WAIT = 8'h20,
      ST_OV_LATCH = 8'h40,
      ST_CODE_OFF = 8'h80
   } vsq_state_type;

   // Off code check
   function automatic logic isOffCode(input logic [CODE_W-1:0] code);
      isOffCode = (code == OFF_CODE_A) || (code == OFF_CODE_B);
   endfunction

   // Setpoint code to reference steps of 6.25 mV
   function automatic logic [REF_W-1:0] codeToSteps(input logic [CODE_W-1:0] code);
      codeToSteps = REF_CODE_BASE - {1'b0, code};
   endfunction
endpackage

// >>> core/vsq_timer.sv
`timescale 1ns/1ns
`default_nettype none
module vsq_timer
   import vsq_pkg::*;
(
   input wire logic clk,                  // System clock
   input wire logic rst,                  // Synchronous reset
   input wire logic clear,                // Restart count from zero
   input wire logic step,                 // Count one unit
   input wire logic [TIMER_W-1:0] limit,  // Units to reach
   output logic done                      // Limit reached
);
   logic [TIMER_W-1:0] count_r;

   // ==========================================================
   // Saturating counter
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         count_r <= '0;
      end else if (step && (count_r < limit)) begin
         count_r <= count_r + 18'h00001;
      end
   end

   assign done = (count_r >= limit);
endmodule
`default_nettype wire

// >>> core/vsq_ramp.sv
`timescale 1ns/1ns
`default_nettype none
module vsq_ramp
   import vsq_pkg::*;
(
   input wire logic clk,                  // System clock
   input wire logic rst,                  // Synchronous reset
   input wire logic clear,                // Return reference to zero
   input wire logic advance,              // Soft-start oscillator tick
   input wire logic [REF_W-1:0] target,   // Setpoint in steps
   output logic [REF_W-1:0] level,        // Internal reference in steps
   output logic atTarget                  // Reference equals setpoint
);
   logic [REF_W-1:0] level_r;

   // ==========================================================
   // One 6.25 mV step per tick toward the setpoint
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         level_r <= '0;
      end else if (advance && (level_r < target)) begin
         level_r <= level_r + 9'h001;
      end else if (advance && (level_r > target)) begin
         level_r <= level_r - 9'h001;
      end
   end

   assign level = level_r;
   assign atTarget = (level_r == target);
endmodule
`default_nettype wire

// >>> core/vsq_sequencer.sv
// Operation
// - Shutdown holds all PWM outputs high impedance except during overvoltage
// - Leave shutdown only with supply, both enables
// - Off code at enable stops until recycled
// - Fixed start wait before the ramp
// - Reference steps once per soft-start tick
// - Power good released after extra delay
// - Power good low in shutdown and faults
// - Undervoltage below 50%, recover at 60%
// - Overvoltage level switches after valid code
// - Overvoltage drives all PWM low fast
// - Below clear level go high impedance
// - Overvoltage latches off until enable recycled
// - Average overcurrent triggers hiccup immediately
// - Overcurrent hiccup 4096 cycles then retry
// - Channel peak limit cuts rest of cycle
`timescale 1ns/1ns
`default_nettype none
module vsq_sequencer
   import vsq_pkg::*;
#(
   parameter int START_WAIT_CYCLES = START_WAIT_CYC,  // Start wait in clocks
   parameter int GOOD_DELAY_CYCLES = GOOD_DELAY_CYC   // Power good delay in clocks
)
(
   input wire logic clk,                              // System clock
   input wire logic rst,                              // Synchronous reset
   input wire logic [11:0] paddr,                     // APB address
   input wire logic psel,                             // APB select
   input wire logic penable,                          // APB enable
   input wire logic pwrite,                           // APB direction
   input wire logic [31:0] pwdata,                    // APB write data
   output logic [31:0] prdata,                        // APB read data
   output logic pready,                               // APB ready
   output logic pslverr,                              // APB error
   output logic irq,                                  // Interrupt level
   input wire logic porOk,                            // Supply above reset level
   input wire logic power_enable_in,                  // Power enable above level
   input wire logic tracking_rail_enable_in,          // Tracking enable above level
   input wire logic [CODE_W-1:0] setpoint_code,       // Setpoint code
   input wire logic uvBelowLow,                       // Output below 50% setpoint
   input wire logic uvAboveHigh,                      // Output above 60% setpoint
   input wire logic ovAbovePreEnable,                 // Sense above fixed level
   input wire logic ovAboveSetpoint,                  // Sense above setpoint plus margin
   input wire logic ovBelowClear,                     // Difference below reference plus margin
   input wire logic average_channel_current_over,     // Average current over reference
   input wire logic [CHANNELS-1:0] chanOverCurrent,   // Channel peak over reference
   input wire logic ssTick,                           // Soft-start oscillator tick
   input wire logic swCycleStart,                     // Switching cycle start pulse
   input wire logic [CHANNELS-1:0] pwmDemand,         // Modulator PWM request
   output logic [CHANNELS-1:0] pwmOut,                // PWM level
   output logic [CHANNELS-1:0] pwmOe,                 // PWM drive enable
   output logic power_good_out,                       // Power good level, always low
   output logic powerGoodOe,                          // Power good pull-down enable
   output logic [REF_W-1:0] refLevel                  // Internal reference steps
);
   vsq_state_type stateR;
   vsq_state_type stateNxt;
   logic holdOffR;
   logic useSetpointOvR;
   logic ovLowR;
   logic uvFaultR;
   logic [CHANNELS-1:0] chanLimitR;
   logic [INT_W-1:0] intStatR;
   logic [INT_W-1:0] intMaskR;
   logic [INT_W-1:0] events;
   logic enOk;
   logic ovTrip;
   logic ovDriveLow;
   logic normalRun;
   logic ocTrip;
   logic delayDone;
   logic hiccupDone;
   logic atTarget;
   logic [REF_W-1:0] target;
   logic [TIMER_W-1:0] delayLimit;
   logic apbAccess;
   logic apbWrite;
   logic pgPrevR;

   // ==========================================================
   // Condition decode
   // Inputs are already synchronised comparator bits
   assign enOk = porOk && power_enable_in && tracking_rail_enable_in && !holdOffR;
   assign ovTrip = useSetpointOvR ? ovAboveSetpoint : ovAbovePreEnable;
   assign ovDriveLow = ovTrip || (ovLowR && !ovBelowClear);
   assign normalRun = enOk && ((stateR == ST_RAMP) || (stateR == ST_GOOD_DLY) || (stateR == ST_RUN));
   assign ocTrip = normalRun && average_channel_current_over;
   assign target = codeToSteps(setpoint_code);
   assign delayLimit = (stateR == ST_WAIT) ? TIMER_W'(START_WAIT_CYCLES) : TIMER_W'(GOOD_DELAY_CYCLES);

   // ==========================================================
   // Timers and reference ramp
   vsq_timer delayTimer (
      .clk(clk),
      .rst(rst),
      .clear(stateR != stateNxt),
      .step(1'b1),
      .limit(delayLimit),
      .done(delayDone)
   );

   vsq_timer hiccupTimer (
      .clk(clk),
      .rst(rst),
      .clear(stateR != ST_OC_WAIT),
      .step(swCycleStart),
      .limit(HICCUP_SW_CYCLES),
      .done(hiccupDone)
   );

   vsq_ramp refRamp (
      .clk(clk),
      .rst(rst),
      .clear(!normalRun),
      .advance(ssTick),
      .target(target),
      .level(refLevel),
      .atTarget(atTarget)
   );

   // ==========================================================
   // Next state
   always_comb begin
      stateNxt = stateR;
      if (!enOk) begin
         stateNxt = ST_OFF;
      end else if (ovTrip) begin
         stateNxt = ST_OV_LATCH;
      end else begin
         case (stateR)
            ST_OFF: begin
               if (isOffCode(setpoint_code)) begin
                  stateNxt = ST_CODE_OFF;
               end else begin
                  stateNxt = ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (delayDone) begin
                  stateNxt = ST_RAMP;
               end
            end
            ST_RAMP: begin
               if (ocTrip) begin
                  stateNxt = ST_OC_WAIT;
               end else if (atTarget) begin
                  stateNxt = ST_GOOD_DLY;
               end
            end
            ST_GOOD_DLY: begin
               if (ocTrip) begin
                  stateNxt = ST_OC_WAIT;
               end else if (delayDone) begin
                  stateNxt = ST_RUN;
               end
            end
            ST_RUN: begin
               if (ocTrip) begin
                  stateNxt = ST_OC_WAIT;
               end
            end
            ST_OC_WAIT: begin
               if (hiccupDone) begin
                  stateNxt = ST_WAIT;
               end
            end
            ST_OV_LATCH: stateNxt = ST_OV_LATCH;
            ST_CODE_OFF: stateNxt = ST_CODE_OFF;
            default: stateNxt = ST_OFF;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         stateR <= ST_OFF;
      end else begin
         stateR <= stateNxt;
      end
   end

   // ==========================================================
   // Overvoltage level select and low-drive memory
   always_ff @(posedge clk) begin
      if (rst || !enOk) begin
         useSetpointOvR <= 1'b0;
      end else if (!isOffCode(setpoint_code)) begin
         useSetpointOvR <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !porOk) begin
         ovLowR <= 1'b0;
      end else begin
         ovLowR <= ovDriveLow;
      end
   end

   // ==========================================================
   // Undervoltage with hysteresis, set wins
   always_ff @(posedge clk) begin
      if (rst) begin
         uvFaultR <= 1'b0;
      end else if (uvBelowLow) begin
         uvFaultR <= 1'b1;
      end else if (uvAboveHigh) begin
         uvFaultR <= 1'b0;
      end
   end

   // Channel peak limit, held to the next switching cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         chanLimitR <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (chanOverCurrent[i]) begin
               chanLimitR[i] <= 1'b1;
            end else if (swCycleStart) begin
               chanLimitR[i] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // PWM outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         pwmOe <= '0;
         pwmOut <= '0;
      end else if (porOk && ovDriveLow) begin
         pwmOe <= '1;
         pwmOut <= '0;
      end else if (normalRun && !ocTrip && (stateR != ST_OV_LATCH)) begin
         pwmOe <= '1;
         pwmOut <= pwmDemand & ~(chanLimitR | chanOverCurrent);
      end else begin
         pwmOe <= '0;
         pwmOut <= '0;
      end
   end

   // Power good, open drain, released only in steady run
   always_ff @(posedge clk) begin
      if (rst) begin
         powerGoodOe <= 1'b1;
         power_good_out <= 1'b0;
         pgPrevR <= 1'b0;
      end else begin
         powerGoodOe <= !((stateR == ST_RUN) && enOk && !uvFaultR && !ovDriveLow && !ocTrip);
         power_good_out <= 1'b0;
         pgPrevR <= !powerGoodOe;
      end
   end

   // ==========================================================
   // Interrupt events
   assign events[EV_OV] = ovDriveLow && !ovLowR;
   assign events[EV_OC] = (stateNxt == ST_OC_WAIT) && (stateR != ST_OC_WAIT);
   assign events[EV_UV] = uvBelowLow && !uvFaultR;
   assign events[EV_PG_RISE] = !powerGoodOe && !pgPrevR;
   assign events[EV_CODE_OFF] = (stateNxt == ST_CODE_OFF) && (stateR != ST_CODE_OFF);

   // ==========================================================
   // APB slave, one wait state
   assign apbAccess = psel && penable && !pready;
   assign apbWrite = apbAccess && pwrite;

   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= apbAccess;
         pslverr <= 1'b0;
         prdata <= '0;
         if (apbAccess && !pwrite) begin
            if (paddr == ADDR_CTRL) begin
               prdata <= {31'h00000000, holdOffR};
            end else if (paddr == ADDR_STATUS) begin
               prdata <= {8'h00, 3'h0, refLevel, uvFaultR, ovLowR, useSetpointOvR, !powerGoodOe, stateR};
            end else if (paddr == ADDR_INT_STAT) begin
               prdata <= {27'h0000000, intStatR};
            end else if (paddr == ADDR_INT_MASK) begin
               prdata <= {27'h0000000, intMaskR};
            end else begin
               pslverr <= 1'b1;
            end
         end else if (apbWrite) begin
            pslverr <= !((paddr == ADDR_CTRL) || (paddr == ADDR_INT_STAT) || (paddr == ADDR_INT_MASK));
         end
      end
   end

   // Control and mask registers
   always_ff @(posedge clk) begin
      if (rst) begin
         holdOffR <= 1'b0;
         intMaskR <= INT_MASK_RESET;
      end else if (apbWrite && (paddr == ADDR_CTRL)) begin
         holdOffR <= pwdata[CTRL_HOLD_OFF];
      end else if (apbWrite && (paddr == ADDR_INT_MASK)) begin
         intMaskR <= pwdata[INT_W-1:0];
      end
   end

   // Sticky status, write one to clear, new event wins
   always_ff @(posedge clk) begin
      if (rst) begin
         intStatR <= '0;
      end else if (apbWrite && (paddr == ADDR_INT_STAT)) begin
         intStatR <= (intStatR & ~pwdata[INT_W-1:0]) | events;
      end else begin
         intStatR <= intStatR | events;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(intStatR & intMaskR);
      end
   end

   // ==========================================================
   // Checks
   a_off_pwm_hiz: assert property (@(posedge clk) disable iff (rst)
      (stateR == ST_OFF && !ovDriveLow && !enOk) |=> (pwmOe == '0))
      else $error("PWM driven in shutdown");
   a_enable_gate: assert property (@(posedge clk) disable iff (rst)
      !enOk |=> (stateR == ST_OFF))
      else $error("Left shutdown without enables");
   a_code_off_hold: assert property (@(posedge clk) disable iff (rst)
      (stateR == ST_CODE_OFF && enOk && !ovTrip) |=> (stateR == ST_CODE_OFF) ##1 (pwmOe == '0 || ovLowR))
      else $error("Off code stop not held");
   a_wait_before_ramp: assert property (@(posedge clk) disable iff (rst)
      (stateR == ST_WAIT && $past(stateR) != ST_WAIT) |-> (stateR != ST_RAMP)[*8])
      else $error("Start wait cut short");
   a_ramp_step: assert property (@(posedge clk) disable iff (rst)
      (stateR == ST_RAMP && enOk && ssTick && refLevel < target) |=> (refLevel == $past(refLevel) + 9'h001))
      else $error("Reference did not step");
   a_good_release: assert property (@(posedge clk) disable iff (rst)
      $fell(powerGoodOe) |-> ($past(stateR) == ST_RUN))
      else $error("Power good released early");
   a_uv_pull_low: assert property (@(posedge clk) disable iff (rst)
      uvBelowLow |=> ##1 powerGoodOe)
      else $error("Undervoltage left power good high");
   a_ov_low_fast: assert property (@(posedge clk) disable iff (rst)
      (porOk && ovTrip) |=> (pwmOe == '1 && pwmOut == '0))
      else $error("Overvoltage did not drive PWM low");
   a_ov_latched: assert property (@(posedge clk) disable iff (rst)
      (stateR == ST_OV_LATCH && enOk) |=> (stateR == ST_OV_LATCH))
      else $error("Overvoltage latch released");
   a_oc_hiz: assert property (@(posedge clk) disable iff (rst)
      (ocTrip && !ovDriveLow) |=> (pwmOe == '0) ##1 (stateR != ST_RUN))
      else $error("Overcurrent left PWM driven");
   a_chan_limit: assert property (@(posedge clk) disable iff (rst)
      ((|chanOverCurrent) && !ovDriveLow) |=> ((pwmOut & $past(chanOverCurrent)) == '0))
      else $error("Channel limit ignored");
   c_reach_run: cover property (@(posedge clk) disable iff (rst) stateR == ST_RUN && !powerGoodOe);
   c_hiccup_retry: cover property (@(posedge clk) disable iff (rst) stateR == ST_OC_WAIT ##1 stateR == ST_WAIT);
   c_ov_latch: cover property (@(posedge clk) disable iff (rst) $rose(stateR == ST_OV_LATCH));
   c_code_off: cover property (@(posedge clk) disable iff (rst) $rose(stateR == ST_CODE_OFF));
endmodule
`default_nettype wire

// >>> testbench/vsq_drv_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Gate driver and power monitor model
module vsq_drv_model
   import vsq_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic [CHANNELS-1:0] pwmOut, // PWM level
   input wire logic [CHANNELS-1:0] pwmOe, // PWM drive enable
   input wire logic powerGoodOe, // Good pull-down
   output logic drvReady, // Driver bias up
   output logic [CHANNELS-1:0] highOn, // Upper switch on
   output logic [CHANNELS-1:0] lowOn, // Lower switch on
   output logic pgWire // Good line level
);
   logic [3:0] biasCnt_r;
   // Driver bias settles a while after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         biasCnt_r <= 4'h0;
      end else if (biasCnt_r != 4'hf) begin
         biasCnt_r <= biasCnt_r + 4'h1;
      end
   end
   assign drvReady = (biasCnt_r == 4'hf);
   // Floating input keeps both switches off
   assign highOn = pwmOe & pwmOut;
   assign lowOn = pwmOe & ~pwmOut;
   // Line pulled up unless held low
   assign pgWire = ~powerGoodOe;
endmodule
`default_nettype wire

// >>> testbench/vr_startup_fault_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
module vr_startup_fault_sequencer_test
   import vsq_pkg::*;
;
   typedef struct {int s; logic [31:0] e;} vsq_pn_type;
   typedef struct {logic [31:0] e; logic [31:0] m; logic er;} vsq_an_type;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, irq, power_good_out, powerGoodOe, drvReady, pgWire;
   logic porOk = 1'b0, power_enable_in = 1'b0, tracking_rail_enable_in = 1'b0;
   logic uvBelowLow = 1'b0, uvAboveHigh = 1'b1, ovAbovePreEnable = 1'b0;
   logic ovAboveSetpoint = 1'b0, ovBelowClear = 1'b1, average_channel_current_over = 1'b0;
   logic ssTick = 1'b0, swCycleStart = 1'b0;
   logic [CODE_W-1:0] setpoint_code = 8'hf0;
   logic [CHANNELS-1:0] chanOverCurrent = 6'h00, pwmDemand = 6'h00, pwmOut, pwmOe, lowOn, highOn;
   logic [REF_W-1:0] refLevel, tgt;
   int n_fail = 0, check_count = 0, c, k;
   vsq_pn_type portQ[$];
   vsq_an_type apbQ[$];
   vsq_pn_type pn;
   vsq_an_type an;
   string nm[6] = '{"pwmOe", "pwmOut", "pgWire", "refLevel", "irq", "lowOn"};

   // ==========================================
   // Clock and instances
   always #5 clk = ~clk;
   vsq_sequencer #(.START_WAIT_CYCLES(20), .GOOD_DELAY_CYCLES(10)) vsq_sequencer_inst (.clk, .rst, .paddr,
      .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq, .porOk, .power_enable_in,
      .tracking_rail_enable_in, .setpoint_code, .uvBelowLow, .uvAboveHigh, .ovAbovePreEnable,
      .ovAboveSetpoint, .ovBelowClear, .average_channel_current_over, .chanOverCurrent, .ssTick,
      .swCycleStart, .pwmDemand, .pwmOut, .pwmOe, .power_good_out, .powerGoodOe, .refLevel);
   vsq_drv_model vsq_drv_model_inst (.clk, .rst, .pwmOut, .pwmOe, .powerGoodOe, .drvReady, .highOn,
      .lowOn, .pgWire);

   // ==========================================
   // Helpers
   task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task tmo;
      n_fail++;
      final_report();
   endtask
   function automatic logic [31:0] obs(input int s);
      case (s)
         0: obs = 32'(pwmOe);
         1: obs = 32'(pwmOut);
         2: obs = 32'(pgWire);
         3: obs = 32'(refLevel);
         4: obs = 32'(irq);
         default: obs = 32'(lowOn);
      endcase
   endfunction
   task note(input int s, input logic [31:0] e);
      portQ.push_back('{s, e});
   endtask
   // One APB transfer, held until pready is sampled
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [31:0] e,
            input logic [31:0] m, input logic er);
      int n;
      apbQ.push_back('{e, w ? 32'h0 : m, er});
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) tmo();
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task state(input logic [7:0] e);
      apb(ADDR_STATUS, 1'b0, 32'h0, {24'h0, e}, 32'hff, 1'b0);
   endtask
   task pulse(input logic sw, input int n);
      repeat (n) begin
         @(posedge clk);
         if (sw) swCycleStart <= 1'b1;
         else ssTick <= 1'b1;
         @(posedge clk);
         swCycleStart <= 1'b0;
         ssTick <= 1'b0;
      end
   endtask
   // Looks on falling edges only, hands back on a rising edge
   task waitFor(input int s, input logic [31:0] e, input int lim);
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while (obs(s) !== e && c < lim);
      if (obs(s) !== e) tmo();
      @(posedge clk);
   endtask

   // ==========================================
   // Monitors take notes oldest first and compare
   always @(negedge clk) begin
      while (portQ.size() > 0) begin
         pn = portQ.pop_front();
         check(nm[pn.s], obs(pn.s), pn.e);
      end
   end
   always @(posedge clk) begin
      if (pready === 1'b1 && apbQ.size() > 0) begin
         an = apbQ.pop_front();
         check("pslverr", 32'(pslverr), 32'(an.er));
         check("prdata", prdata & an.m, an.e);
      end
   end
   initial begin
      repeat (100000) @(posedge clk);
      tmo();
   end

   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(84));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      note(0, 0);
      note(2, 0);
      apb(ADDR_CTRL, 1'b0, 32'h0, 32'h0, 32'hffffffff, 1'b0);
      apb(ADDR_INT_MASK, 1'b0, 32'h0, 32'h0, 32'hffffffff, 1'b0);
      apb(12'h010, 1'b0, 32'h0, 32'h0, 32'hffffffff, 1'b1);
      apb(12'h014, 1'b1, 32'h5a5a5a5a, 32'h0, 32'h0, 1'b1);
      porOk <= 1'b1;
      ovAbovePreEnable <= 1'b1;
      @(posedge clk);
      note(5, 32'h3f);
      ovAbovePreEnable <= 1'b0;
      waitFor(0, 0, 3);
      note(4, 0);
      apb(ADDR_INT_MASK, 1'b1, 32'h1f, 32'h0, 32'h0, 1'b0);
      waitFor(4, 1, 3);
      apb(ADDR_INT_STAT, 1'b1, 32'h1f, 32'h0, 32'h0, 1'b0);
      waitFor(4, 0, 3);
      state(8'h01);
      $display("test reset and early trip done");
      c = 0;
      while (drvReady !== 1'b1 && c < 40) begin
         @(posedge clk);
         c++;
      end
      if (drvReady !== 1'b1) tmo();
      for (int i = 0; i < 2; i++) begin
         setpoint_code <= i ? OFF_CODE_B : OFF_CODE_A;
         power_enable_in <= 1'b1;
         tracking_rail_enable_in <= 1'b1;
         state(8'h80);
         setpoint_code <= 8'hf0;
         state(8'h80);
         tracking_rail_enable_in <= 1'b0;
         state(8'h01);
      end
      $display("test off codes done");
      apb(ADDR_INT_STAT, 1'b1, 32'h1f, 32'h0, 32'h0, 1'b0);
      setpoint_code <= 8'he0 + 8'($urandom % 24);
      tracking_rail_enable_in <= 1'b1;
      @(posedge clk);
      tgt = 9'h102 - {1'b0, setpoint_code};
      waitFor(0, 32'h3f, 60);
      check("startWait", 32'(c > 20 && c <= 24), 1);
      for (int i = 1; i <= tgt; i++) begin
         pulse(1'b0, 1);
         note(3, i);
      end
      waitFor(2, 1, 40);
      check("goodDelay", 32'(c > 10 && c <= 14), 1);
      waitFor(4, 1, 3);
      apb(ADDR_INT_STAT, 1'b0, 32'h0, 32'h8, 32'h1f, 1'b0);
      apb(ADDR_INT_STAT, 1'b1, 32'h8, 32'h0, 32'h0, 1'b0);
      waitFor(4, 0, 3);
      $display("test startup done");
      uvAboveHigh <= 1'b0;
      uvBelowLow <= 1'b1;
      waitFor(2, 0, 4);
      uvBelowLow <= 1'b0;
      repeat (4) @(posedge clk);
      note(2, 0);
      uvAboveHigh <= 1'b1;
      waitFor(2, 1, 4);
      k = $urandom % CHANNELS;
      pwmDemand <= 6'h3f;
      @(posedge clk);
      chanOverCurrent[k] <= 1'b1;
      @(posedge clk);
      note(1, 6'h3f & ~(6'h01 << k));
      chanOverCurrent[k] <= 1'b0;
      repeat (3) @(posedge clk);
      note(1, 6'h3f & ~(6'h01 << k));
      pulse(1'b1, 1);
      waitFor(1, 32'h3f, 3);
      note(2, 1);
      check("power_good_out", 32'(power_good_out), 32'h0);
      $display("test undervoltage and channel limit done");
      average_channel_current_over <= 1'b1;
      @(posedge clk);
      average_channel_current_over <= 1'b0;
      note(0, 0);
      waitFor(2, 0, 3);
      pulse(1'b1, 4095);
      state(8'h20);
      pulse(1'b1, 1);
      state(8'h02);
      $display("test hiccup done");
      ovAboveSetpoint <= 1'b1;
      ovBelowClear <= 1'b0;
      @(posedge clk);
      note(5, 32'h3f);
      ovAboveSetpoint <= 1'b0;
      ovBelowClear <= 1'b1;
      waitFor(0, 0, 3);
      ovAboveSetpoint <= 1'b1;
      ovBelowClear <= 1'b0;
      @(posedge clk);
      note(5, 32'h3f);
      ovAboveSetpoint <= 1'b0;
      ovBelowClear <= 1'b1;
      setpoint_code <= 8'he8;
      state(8'h40);
      porOk <= 1'b0;
      state(8'h01);
      note(2, 0);
      porOk <= 1'b1;
      state(8'h02);
      $display("test overvoltage latch done");
      final_report();
   end
endmodule
`default_nettype wire
